// File: rtl/cca_pkg.sv
// Purpose: Shared constants and types for the channel access block
// Assumes: 40 MHz ref_clk, 2.4 GHz symbol time of 16 us
// Notes: Registers sit at byte address four times their index
package cca_pkg;
	// Register indices, byte address is index times four
	localparam logic [5:0] IDX_TX_MAC_CONTROL = 6'h11;
	localparam logic [5:0] IDX_TX_PENDING_LONG_IFS = 6'h21;
	localparam logic [5:0] IDX_TURNAROUND_TIME = 6'h27;
	localparam logic [5:0] IDX_SETTLE_AND_SHORT_IFS = 6'h2E;
	localparam logic [5:0] IDX_ACCESS_STATUS = 6'h30;

	// Reset values, nominal spacing split as part plus settle
	localparam logic [7:0] RST_TX_MAC_CONTROL = 8'h1C;
	localparam logic [7:0] RST_TX_PENDING_LONG_IFS = 8'h98;
	localparam logic [7:0] RST_TURNAROUND_TIME = 8'hA0;
	localparam logic [7:0] RST_SETTLE_AND_SHORT_IFS = 8'h2A;

	// Field positions
	localparam int NO_CSMA_BIT = 7;
	localparam int BATTERY_SAVING_EXT_BIT = 6;
	localparam int SLOTTED_BIT = 5;
	localparam int MIN_BACKOFF_EXP_MSB = 4;
	localparam int MIN_BACKOFF_EXP_LSB = 3;
	localparam int MAX_BACKOFF_COUNT_MSB = 2;
	localparam int MAX_BACKOFF_COUNT_LSB = 0;
	localparam int LONG_SPACING_PART_MSB = 7;
	localparam int LONG_SPACING_PART_LSB = 2;
	localparam int TURNAROUND_PART_MSB = 7;
	localparam int TURNAROUND_PART_LSB = 4;
	localparam int RF_SETTLE_PART_MSB = 7;
	localparam int RF_SETTLE_PART_LSB = 4;
	localparam int SHORT_SPACING_PART_MSB = 3;
	localparam int SHORT_SPACING_PART_LSB = 0;
	localparam logic [7:0] TURNAROUND_RSVD_MASK = 8'hF0;

	// Algorithm limits
	localparam logic [2:0] MAX_BACKOFF_COUNT_LIMIT = 3'h5;
	localparam logic [2:0] MAX_BE = 3'h5;
	localparam logic [2:0] BLE_BE = 3'h2;
	localparam logic [1:0] CW_INIT = 2'h2;
	localparam logic [6:0] SHORT_FRAME_MAX = 7'h12;
	localparam logic [15:0] LFSR_SEED = 16'hACE1; // Arbitrary seed

	// Timing: symbol time and backoff period length
	localparam int CLK_PERIOD_NS = 25;
	localparam int SYMBOL_NS = 16000;
	localparam int SYM_CYC = (SYMBOL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [9:0] SYM_LAST = 10'(SYM_CYC - 1);
	localparam logic [4:0] BOP_SYM_LAST = 5'h13; // 20 symbols per period

	// Frame kinds offered on the transmit port
	typedef enum logic [1:0] {
		KIND_DATA,
		KIND_ACK,
		KIND_BEACON,
		KIND_CMD
	} cca_kind_t;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_BACKOFF,
		ST_CCA,
		ST_TURN,
		ST_SEND,
		ST_ACKWAIT,
		ST_IFS
	} cca_state_t;
endpackage

// File: rtl/cca_time_if.sv
// Purpose: Ticks and interval timer signals inside the block
// Assumes: Single ref_clk domain
// Notes: Load is a one-cycle pulse from the core
`timescale 1ns/1ps
interface cca_time_if;
	logic symTick;
	logic bopTick;
	logic tmrLoad;
	logic [6:0] tmrValue;
	logic tmrDone;

	modport ticker (output symTick, output bopTick);
	modport timer (input tmrLoad, input tmrValue, output tmrDone);
	modport core (input symTick, input bopTick, input tmrDone,
		output tmrLoad, output tmrValue);
endinterface

// File: rtl/cca_symbol_ticker.sv
// Purpose: Free-running symbol and backoff period enables
// Assumes: ref_clk at 40 MHz
// Notes: Own phase, unrelated to any other node
`timescale 1ns/1ps
module cca_symbol_ticker
	import cca_pkg::*;
(
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// Tick outputs
	cca_time_if.ticker tk
);
	logic [9:0] cycQ_q, cycQ_d;
	logic [4:0] symQ_q, symQ_d;

	////////////////////////////////////////////////////////////////////
	// Divider next state
	always_comb begin
		cycQ_d = (cycQ_q == SYM_LAST) ? 10'h000 : cycQ_q + 10'h001;
		symQ_d = symQ_q;
		if (cycQ_q == SYM_LAST) begin
			symQ_d = (symQ_q == BOP_SYM_LAST) ? 5'h00 : symQ_q + 5'h01;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			cycQ_q <= 10'h000;
			symQ_q <= 5'h00;
		end else begin
			cycQ_q <= cycQ_d;
			symQ_q <= symQ_d;
		end
	end

	// Pulses last exactly one ref_clk cycle
	assign tk.symTick = (cycQ_q == SYM_LAST);
	assign tk.bopTick = (cycQ_q == SYM_LAST) && (symQ_q == BOP_SYM_LAST);
endmodule

// File: rtl/cca_interval_timer.sv
// Purpose: Symbol-count interval timer for spacing and turnaround
// Assumes: Load pulse carries a count of whole symbols
// Notes: Own prescaler restarts on load so no partial symbol is lost
`timescale 1ns/1ps
module cca_interval_timer
	import cca_pkg::*;
(
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// Timer control
	cca_time_if.timer tm
);
	logic [6:0] remQ_q, remQ_d;
	logic [9:0] preQ_q, preQ_d;

	////////////////////////////////////////////////////////////////////
	// Count whole symbols down to zero
	always_comb begin
		remQ_d = remQ_q;
		preQ_d = preQ_q;
		if (tm.tmrLoad) begin
			remQ_d = tm.tmrValue;
			preQ_d = 10'h000;
		end else if (remQ_q != 7'h00) begin
			if (preQ_q == SYM_LAST) begin
				preQ_d = 10'h000;
				remQ_d = remQ_q - 7'h01;
			end else begin
				preQ_d = preQ_q + 10'h001;
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			remQ_q <= 7'h00;
			preQ_q <= 10'h000;
		end else begin
			remQ_q <= remQ_d;
			preQ_q <= preQ_d;
		end
	end

	assign tm.tmrDone = (remQ_q == 7'h00);
endmodule

// File: rtl/cca_csma_ifs.sv
// Purpose: CSMA-CA channel access and interframe spacing control
// Assumes: Radio front end gives CCA results and end-of-frame pulses
// Notes: Registers reached over Avalon-MM, one wait state per access
`timescale 1ns/1ps
module cca_csma_ifs
	import cca_pkg::*;
(
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// Avalon-MM register slave
	input wire logic [7:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	// Transmit request port
	input wire logic txReq,
	input wire logic [1:0] txKind,
	input wire logic [6:0] txLen,
	input wire logic txAckReq,
	output logic txReady,
	output logic txGo,
	output logic txFail,
	// Radio side
	input wire logic slotBoundary,
	output logic ccaReq,
	input wire logic ccaDone,
	input wire logic ccaClear,
	input wire logic txDone,
	input wire logic ackDone
);
	cca_time_if tif ();

	cca_symbol_ticker uTicker (
		.ref_clk(ref_clk),
		.rst(rst),
		.tk(tif.ticker)
	);

	cca_interval_timer uTimer (
		.ref_clk(ref_clk),
		.rst(rst),
		.tm(tif.timer)
	);

	////////////////////////////////////////////////////////////////////
	// Register file and bus slave
	logic [7:0] macCtrl_q, macCtrl_d;
	logic [7:0] pendLifs_q, pendLifs_d;
	logic [7:0] turnaround_part_q, turnaround_part_d;
	logic [7:0] settleSifs_q, settleSifs_d;
	logic ack_q, ack_d;
	logic [31:0] rdData_q, rdData_d;
	logic [7:0] rdMux;
	logic [7:0] statusByte;
	logic [5:0] regIdx;
	logic wrStb;
	logic [7:0] wrByte;

	assign regIdx = avs_address[7:2];
	assign wrByte = avs_writedata[7:0];
	// Write lands on the edge where waitrequest is low
	assign wrStb = avs_write && ack_q && avs_byteenable[0];
	assign avs_waitrequest = (avs_read || avs_write) && !ack_q;
	assign avs_readdata = rdData_q;

	// Read mux, unmapped addresses read zero
	always_comb begin
		if (regIdx == IDX_TX_MAC_CONTROL) begin
			rdMux = macCtrl_q;
		end else if (regIdx == IDX_TX_PENDING_LONG_IFS) begin
			rdMux = pendLifs_q;
		end else if (regIdx == IDX_TURNAROUND_TIME) begin
			rdMux = turnaround_part_q;
		end else if (regIdx == IDX_SETTLE_AND_SHORT_IFS) begin
			rdMux = settleSifs_q;
		end else if (regIdx == IDX_ACCESS_STATUS) begin
			rdMux = statusByte;
		end else begin
			rdMux = 8'h00;
		end
	end

	// Write decode and handshake next values
	always_comb begin
		macCtrl_d = macCtrl_q;
		pendLifs_d = pendLifs_q;
		turnaround_part_d = turnaround_part_q;
		settleSifs_d = settleSifs_q;
		ack_d = (avs_read || avs_write) && !ack_q;
		rdData_d = rdData_q;
		if (avs_read && !ack_q) begin
			rdData_d = {24'h000000, rdMux};
		end
		if (wrStb) begin
			if (regIdx == IDX_TX_MAC_CONTROL) begin
				macCtrl_d = wrByte;
				// Counts above the legal top are held at the top
				if (wrByte[MAX_BACKOFF_COUNT_MSB:MAX_BACKOFF_COUNT_LSB] >
					MAX_BACKOFF_COUNT_LIMIT) begin
					macCtrl_d[MAX_BACKOFF_COUNT_MSB:MAX_BACKOFF_COUNT_LSB] =
						MAX_BACKOFF_COUNT_LIMIT;
				end
			end else if (regIdx == IDX_TX_PENDING_LONG_IFS) begin
				pendLifs_d = wrByte;
			end else if (regIdx == IDX_TURNAROUND_TIME) begin
				turnaround_part_d = wrByte & TURNAROUND_RSVD_MASK;
			end else if (regIdx == IDX_SETTLE_AND_SHORT_IFS) begin
				settleSifs_d = wrByte;
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			macCtrl_q <= RST_TX_MAC_CONTROL;
			pendLifs_q <= RST_TX_PENDING_LONG_IFS;
			turnaround_part_q <= RST_TURNAROUND_TIME;
			settleSifs_q <= RST_SETTLE_AND_SHORT_IFS;
			ack_q <= 1'b0;
			rdData_q <= 32'h00000000;
		end else begin
			macCtrl_q <= macCtrl_d;
			pendLifs_q <= pendLifs_d;
			turnaround_part_q <= turnaround_part_d;
			settleSifs_q <= settleSifs_d;
			ack_q <= ack_d;
			rdData_q <= rdData_d;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Derived settings
	logic slotted;
	logic batterySavingExt;
	logic [2:0] minBackoffExp;
	logic [2:0] maxBackoffCount;
	logic [6:0] shortIfs;
	logic [6:0] longIfs;
	logic [6:0] turnaround;
	logic [3:0] rfSettle;

	assign slotted = macCtrl_q[SLOTTED_BIT];
	// Only meaningful with slotted access
	assign batterySavingExt = macCtrl_q[BATTERY_SAVING_EXT_BIT] && slotted;
	assign minBackoffExp =
		{1'b0, macCtrl_q[MIN_BACKOFF_EXP_MSB:MIN_BACKOFF_EXP_LSB]};
	assign maxBackoffCount =
		macCtrl_q[MAX_BACKOFF_COUNT_MSB:MAX_BACKOFF_COUNT_LSB];
	assign rfSettle = settleSifs_q[RF_SETTLE_PART_MSB:RF_SETTLE_PART_LSB];
	assign shortIfs = 7'(settleSifs_q[SHORT_SPACING_PART_MSB:
		SHORT_SPACING_PART_LSB]) + 7'(rfSettle);
	assign longIfs = 7'(pendLifs_q[LONG_SPACING_PART_MSB:
		LONG_SPACING_PART_LSB]) + 7'(rfSettle);
	assign turnaround = 7'(turnaround_part_q[TURNAROUND_PART_MSB:
		TURNAROUND_PART_LSB]) + 7'(rfSettle);

	////////////////////////////////////////////////////////////////////
	// Channel access state machine
	cca_state_t state_q, state_d;
	logic [2:0] nb_q, nb_d;
	logic [2:0] be_q, be_d;
	logic [1:0] cw_q, cw_d;
	logic [4:0] boCnt_q, boCnt_d;
	logic [15:0] lfsr_q, lfsr_d;
	logic frmLong_q, frmLong_d;
	logic frmAck_q, frmAck_d;
	logic failLatch_q, failLatch_d;
	logic go_q, go_d;
	logic fail_q, fail_d;
	logic ccaReq_q, ccaReq_d;
	logic boTick;
	logic direct;
	logic [4:0] beMask;
	logic [2:0] beStart;
	logic [2:0] beInc;

	// Slotted backoff steps only on coordinator slot boundaries
	assign boTick = slotted ? slotBoundary : tif.bopTick;
	assign direct = (txKind == KIND_ACK) || (txKind == KIND_BEACON);
	// Acks and beacons may leave during spacing, data must wait
	assign txReady = (state_q == ST_IDLE) ||
		((state_q == ST_IFS) && direct);
	// Window for a retry draw, one step above the current exponent, held at MAX_BE
	assign beMask = ~(5'h1F << beInc);
	assign beStart = (batterySavingExt && minBackoffExp > BLE_BE) ?
		BLE_BE : minBackoffExp;
	assign beInc = (be_q >= MAX_BE) ? MAX_BE : be_q + 3'h1;
	assign txGo = go_q;
	assign txFail = fail_q;
	assign ccaReq = ccaReq_q;
	assign statusByte = {failLatch_q, nb_q, 1'b0, state_q};

	always_comb begin
		state_d = state_q;
		nb_d = nb_q;
		be_d = be_q;
		cw_d = cw_q;
		boCnt_d = boCnt_q;
		frmLong_d = frmLong_q;
		frmAck_d = frmAck_q;
		failLatch_d = failLatch_q;
		go_d = 1'b0;
		fail_d = 1'b0;
		ccaReq_d = ccaReq_q;
		tif.tmrLoad = 1'b0;
		tif.tmrValue = 7'h00;
		// Pseudo-random source for backoff draws
		lfsr_d = {lfsr_q[14:0],
			lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10]};
		if (txReq && txReady) begin
			frmLong_d = (txLen > SHORT_FRAME_MAX);
			frmAck_d = txAckReq && !direct;
			if (direct) begin
				go_d = 1'b1;
				state_d = ST_SEND;
			end else begin
				nb_d = 3'h0;
				be_d = beStart;
				cw_d = CW_INIT;
				boCnt_d = lfsr_q[4:0] & ~(5'h1F << beStart);
				failLatch_d = 1'b0;
				state_d = ST_BACKOFF;
			end
		end else begin
			case (state_q)
				ST_BACKOFF: begin
					if (boCnt_q == 5'h00 && (!slotted || boTick)) begin
						ccaReq_d = 1'b1;
						state_d = ST_CCA;
					end else if (boTick) begin
						boCnt_d = boCnt_q - 5'h01;
					end
				end
				ST_CCA: begin
					if (ccaDone) begin
						ccaReq_d = 1'b0;
						if (ccaClear) begin
							if (slotted && cw_q > 2'h1) begin
								// Second clear check at the next boundary
								cw_d = cw_q - 2'h1;
								boCnt_d = 5'h00;
								state_d = ST_BACKOFF;
							end else begin
								tif.tmrLoad = 1'b1;
								tif.tmrValue = turnaround;
								state_d = ST_TURN;
							end
						end else if (nb_q >= maxBackoffCount) begin
							fail_d = 1'b1;
							failLatch_d = 1'b1;
							state_d = ST_IDLE;
						end else begin
							nb_d = nb_q + 3'h1;
							be_d = beInc;
							cw_d = CW_INIT;
							boCnt_d = lfsr_q[4:0] & beMask;
							state_d = ST_BACKOFF;
						end
					end
				end
				ST_TURN: begin
					if (tif.tmrDone) begin
						go_d = 1'b1;
						state_d = ST_SEND;
					end
				end
				ST_SEND: begin
					if (txDone) begin
						if (frmAck_q) begin
							state_d = ST_ACKWAIT;
						end else begin
							tif.tmrLoad = 1'b1;
							tif.tmrValue = frmLong_q ? longIfs : shortIfs;
							state_d = ST_IFS;
						end
					end
				end
				ST_ACKWAIT: begin
					// Spacing counts from the end of the acknowledgment
					if (ackDone) begin
						tif.tmrLoad = 1'b1;
						tif.tmrValue = frmLong_q ? longIfs : shortIfs;
						state_d = ST_IFS;
					end
				end
				ST_IFS: begin
					if (tif.tmrDone) begin
						state_d = ST_IDLE;
					end
				end
				default: begin
					state_d = ST_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			state_q <= ST_IDLE;
			nb_q <= 3'h0;
			be_q <= 3'h0;
			cw_q <= 2'h0;
			boCnt_q <= 5'h00;
			lfsr_q <= LFSR_SEED;
			frmLong_q <= 1'b0;
			frmAck_q <= 1'b0;
			failLatch_q <= 1'b0;
			go_q <= 1'b0;
			fail_q <= 1'b0;
			ccaReq_q <= 1'b0;
		end else begin
			state_q <= state_d;
			nb_q <= nb_d;
			be_q <= be_d;
			cw_q <= cw_d;
			boCnt_q <= boCnt_d;
			lfsr_q <= lfsr_d;
			frmLong_q <= frmLong_d;
			frmAck_q <= frmAck_d;
			failLatch_q <= failLatch_d;
			go_q <= go_d;
			fail_q <= fail_d;
			ccaReq_q <= ccaReq_d;
		end
	end
endmodule

// File: testbench/cca_csma_ifs_chk.sv
// Purpose: Port-level timing checks of the channel access block
// Assumes: One ref_clk domain, rst synchronous active high
// Notes: Bound to the top module after the checker
`timescale 1ns/1ps
module cca_csma_ifs_chk
	import cca_pkg::*;
(
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// Register bus
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic avs_waitrequest,
	// Transmit and radio
	input wire logic txReq,
	input wire logic [1:0] txKind,
	input wire logic txReady,
	input wire logic txGo,
	input wire logic txFail,
	input wire logic ccaReq,
	input wire logic ccaDone,
	input wire logic txDone
);
	// Kinds that go out without channel assessment
	logic direct;
	assign direct = txKind == KIND_ACK || txKind == KIND_BEACON;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);
	////////////////////////////////////////////////////////////////////////
	bus_one_wait_a: assert property ((avs_read || avs_write) &&
		avs_waitrequest |=> !avs_waitrequest) else $error("bus wait");
	direct_send_a: assert property (
		txReq && txReady && direct |=> txGo && !ccaReq)
		else $error("direct frame late");
	data_busy_a: assert property (
		txReq && txReady && !direct |=> !txReady && !txGo)
		else $error("data frame skipped access");
	go_pulse_a: assert property (txGo |=> !txGo)
		else $error("go too long");
	fail_pulse_a: assert property (txFail |-> !txGo ##1 !txFail)
		else $error("fail pulse bad");
	cca_hold_a: assert property (ccaReq && !ccaDone |=> ccaReq)
		else $error("assessment dropped early");
	cca_drop_a: assert property (ccaReq && ccaDone |-> ##[1:2] !ccaReq)
		else $error("assessment held");
	cca_busy_a: assert property ($rose(ccaReq) |-> !txReady)
		else $error("assessment while idle");
	spacing_hold_a: assert property (
		txDone && !direct |=> !txReady [*2])
		else $error("no spacing after frame");
endmodule

bind cca_csma_ifs cca_csma_ifs_chk u_chk (.ref_clk, .rst, .avs_read,
	.avs_write, .avs_waitrequest, .txReq, .txKind, .txReady, .txGo,
	.txFail, .ccaReq, .ccaDone, .txDone);

// File: testbench/cca_radio_model.sv
// Purpose: Radio front end and channel seen from the block
// Assumes: Fixed air time of 50 cycles, acknowledgment 300 later
// Notes: Assessment lag alternates fast and slow
`timescale 1ns/1ps
module cca_radio_model (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// From block and bench
	input wire logic ccaReq,
	input wire logic txGo,
	input wire logic busy,
	// Radio answers
	output logic ccaDone,
	output logic ccaClear,
	output logic txDone,
	output logic ackDone,
	output logic slotBoundary
);
	int ccaN, txN, ackN, slotN;
	logic slow, flip;
	// Result toggles outside its valid pulse so no stale value helps
	assign ccaClear = ccaDone ? !busy : flip;
	// Assessment, air time, acknowledgment and slot grid
	always @(posedge ref_clk) begin
		if (rst) begin
			{ccaN, txN, ackN, slotN} <= '0;
			{slow, flip, ccaDone, txDone, ackDone, slotBoundary} <= '0;
		end else begin
			flip <= !flip;
			slotN <= slotN == 319 ? 0 : slotN + 1;
			slotBoundary <= slotN == 319;
			ccaN <= ccaReq ? ccaN + 1 : 0;
			ccaDone <= ccaReq && ccaN == (slow ? 40 : 3);
			if (ccaReq && ccaN == (slow ? 40 : 3))
				slow <= !slow;
			txN <= txGo ? 1 : (txN != 0 && txN < 50) ? txN + 1 : 0;
			txDone <= txN == 50;
			ackN <= txN == 50 ? 1 : (ackN != 0 && ackN < 300) ? ackN + 1 : 0;
			ackDone <= ackN == 300;
		end
	end
endmodule

// File: testbench/cca_csma_ifs_tb.sv
// Purpose: Self-checking bench of channel access and spacing
// Assumes: 40 MHz clock, symbol of 640 cycles
// Notes: Turnaround and spacing measured in cycles at the ports
`timescale 1ns/1ps
module cca_csma_ifs_tb;
	import cca_pkg::*;
	logic ref_clk, rst, avs_read, avs_write, avs_waitrequest, busy;
	logic [7:0] avs_address;
	logic [31:0] avs_writedata, avs_readdata, rdv, rnd;
	logic [3:0] avs_byteenable;
	logic txReq, txAckReq, txReady, txGo, txFail, ccaReq, ccaDone;
	logic ccaClear, txDone, ackDone, slotBoundary;
	logic [1:0] txKind;
	logic [6:0] txLen;
	int cyc = 0;
	int ccaCnt = 0;
	int badCount, checked, c0, t0, t1;
	logic [5:0] ix [4] = '{IDX_TX_MAC_CONTROL, IDX_TX_PENDING_LONG_IFS,
		IDX_TURNAROUND_TIME, IDX_SETTLE_AND_SHORT_IFS};
	logic [7:0] rv [4] = '{RST_TX_MAC_CONTROL, RST_TX_PENDING_LONG_IFS,
		RST_TURNAROUND_TIME, RST_SETTLE_AND_SHORT_IFS};

	cca_csma_ifs u_dut (.ref_clk(ref_clk), .rst(rst),
		.avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .txReq(txReq), .txKind(txKind),
		.txLen(txLen), .txAckReq(txAckReq), .txReady(txReady),
		.txGo(txGo), .txFail(txFail), .slotBoundary(slotBoundary),
		.ccaReq(ccaReq), .ccaDone(ccaDone), .ccaClear(ccaClear),
		.txDone(txDone), .ackDone(ackDone));
	cca_radio_model u_radio (.ref_clk(ref_clk), .rst(rst),
		.ccaReq(ccaReq), .txGo(txGo), .busy(busy), .ccaDone(ccaDone),
		.ccaClear(ccaClear), .txDone(txDone), .ackDone(ackDone),
		.slotBoundary(slotBoundary));
	////////////////////////////////////////////////////////////////////////
	// Clock, cycle count and assessment count
	initial begin
		ref_clk = 1'b0;
		forever #12.5 ref_clk = !ref_clk;
	end
	always @(posedge ref_clk) begin
		cyc <= cyc + 1;
		if (ccaDone)
			ccaCnt <= ccaCnt + 1;
	end
	////////////////////////////////////////////////////////////////////////
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	// Stored value: count clipped at five, low turnaround bits zero
	function automatic logic [7:0] regExp(input logic [5:0] i,
		input logic [7:0] d);
		if (i == IDX_TX_MAC_CONTROL && d[2:0] > MAX_BACKOFF_COUNT_LIMIT)
			return {d[7:3], MAX_BACKOFF_COUNT_LIMIT};
		if (i == IDX_TURNAROUND_TIME)
			return d & TURNAROUND_RSVD_MASK;
		return d;
	endfunction
	// Interval of n symbols plus a few cycles of pipeline
	function automatic logic [31:0] inWin(input int d, input int n);
		return 32'(d >= n * 640 && d <= n * 640 + 6);
	endfunction
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			badCount++;
			$display("CHECK FAILED at %0t seen %0h expected %0h", $time,
				seen, exp);
		end
	endtask
	task automatic testDone();
		$display("checks %0d mismatches %0d", checked, badCount);
		if (badCount == 0 && checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	// One Avalon access, held until waitrequest is seen low
	task automatic busAcc(input logic wr, input logic [5:0] i,
		input logic [7:0] d);
		int n;
		n = 0;
		avs_address <= {i, 2'h0};
		avs_writedata <= {24'h0, d};
		avs_write <= wr;
		avs_read <= !wr;
		// Request stands until the edge that sees waitrequest low
		do begin
			@(posedge ref_clk);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 50);
		rdv = avs_readdata;
		if (avs_waitrequest !== 1'b0)
			badCount++;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		@(posedge ref_clk);
	endtask
	// Transmit request held until taken
	task automatic send(input cca_kind_t k, input logic [6:0] l,
		input logic a);
		txReq <= 1'b1;
		txKind <= k;
		txLen <= l;
		txAckReq <= a;
		// Taken at the edge that sees txReady high
		do begin
			@(posedge ref_clk);
		end while (txReady !== 1'b1);
		txReq <= 1'b0;
		txKind <= KIND_DATA;
	endtask
	// Wait for go, done, ack, ready, fail or assessment result
	task automatic waitFor(input int sel, output int t);
		logic s;
		int n;
		n = 0;
		do begin
			@(negedge ref_clk);
			s = sel == 0 ? txGo : sel == 1 ? txDone : sel == 2 ? ackDone :
				sel == 3 ? txReady : sel == 4 ? txFail : ccaDone;
			n++;
		end while (s !== 1'b1 && n < 60000);
		// A wait that runs out is a mismatch
		if (s !== 1'b1)
			badCount++;
		t = cyc;
		@(posedge ref_clk);
	endtask
	////////////////////////////////////////////////////////////////////////
	// Watchdog, well past the expected run
	initial begin
		repeat (90000) @(posedge ref_clk);
		badCount++;
		testDone();
	end
	// Main sequence
	initial begin
		{rst, busy} = 2'b10;
		{avs_read, avs_write, txReq, txAckReq} = '0;
		{avs_address, avs_writedata, txKind, txLen} = '0;
		avs_byteenable = 4'hF;
		{badCount, checked} = '0;
		rnd = 32'h2B3CCD19;
		repeat (3) @(posedge ref_clk);
		rst <= 1'b0;
		for (int i = 0; i < 4; i++) begin
			busAcc(1'b0, ix[i], 8'h00);
			check(rdv, 32'(rv[i]));
		end
		busAcc(1'b0, 6'h05, 8'h00);
		check(rdv, 32'h0);
		for (int i = 0; i < 14; i++) begin
			rnd = lfsr(rnd);
			busAcc(1'b1, ix[rnd[9:8]], rnd[7:0]);
			busAcc(1'b0, ix[rnd[9:8]], 8'h00);
			check(rdv, 32'(regExp(ix[rnd[9:8]], rnd[7:0])));
		end
		// Parts with settle 1: turnaround 2, short 2, long 3 symbols
		busAcc(1'b1, IDX_TURNAROUND_TIME, 8'h10);
		busAcc(1'b1, IDX_SETTLE_AND_SHORT_IFS, 8'h11);
		busAcc(1'b1, IDX_TX_PENDING_LONG_IFS, 8'h08);
		busAcc(1'b1, IDX_TX_MAC_CONTROL, 8'h04);
		c0 = ccaCnt;
		send(KIND_ACK, 7'h05, 1'b0);
		waitFor(0, t0);
		check(32'(ccaCnt - c0), 32'h0);
		waitFor(3, t0);
		// Short frame at the limit, then long frame with acknowledgment
		for (int k = 0; k < 2; k++) begin
			c0 = ccaCnt;
			send(KIND_DATA, 7'(SHORT_FRAME_MAX + k), k[0]);
			waitFor(5, t0);
			waitFor(0, t1);
			check(inWin(t1 - t0, 2), 32'h1);
			check(32'(ccaCnt - c0), 32'h1);
			waitFor(k ? 2 : 1, t0);
			waitFor(3, t1);
			check(inWin(t1 - t0, 2 + k), 32'h1);
		end
		// Busy channel until the backoff count runs out
		busy <= 1'b1;
		for (int m = 0; m < 2; m++) begin
			busAcc(1'b1, IDX_TX_MAC_CONTROL, 8'(m));
			c0 = ccaCnt;
			send(KIND_DATA, 7'h05, 1'b0);
			waitFor(4, t0);
			check(32'(ccaCnt - c0), 32'(m + 1));
		end
		// Status: failure latched, one retry counted, back to idle
		busAcc(1'b0, IDX_ACCESS_STATUS, 8'h00);
		check(rdv, 32'h90);
		busy <= 1'b0;
		// Slotted access needs two clear assessments
		busAcc(1'b1, IDX_TX_MAC_CONTROL, 8'h20);
		c0 = ccaCnt;
		send(KIND_DATA, 7'h05, 1'b0);
		waitFor(0, t0);
		check(32'(ccaCnt - c0), 32'h2);
		waitFor(1, t0);
		waitFor(3, t0);
		testDone();
	end
endmodule
